// [include/tcm_pkg.sv]
// Package for the tightly coupled memory system of the DSP subsystem.
// Assumes one core clock; all buses are sampled on its rising edge.
package tcm_pkg;

   // ***********************************
   // Requesters
   // ***********************************
   localparam int NREQ = 7;
   localparam int REQ_PROG = 0;
   localparam int REQ_DR0 = 1;
   localparam int REQ_DW0 = 4;
   localparam int REQ_DMA = 6;
   localparam logic [NREQ-1:0] REQ_WORD_ADDR = 7'h3e;
   localparam logic [NREQ-1:0] REQ_CAN_WRITE = 7'h70;
   localparam logic [NREQ-1:0] REQ_CAN_IO = 7'h3e;

   // ***********************************
   // Memory map
   // ***********************************
   localparam logic [23:0] DA_BASE = 24'h000000;
   localparam logic [23:0] SA_BASE = 24'h010000;
   localparam logic [23:0] EXT_BASE = 24'h028000;
   localparam logic [23:0] ROM_BASE = 24'hff8000;
   localparam int BANK_BYTES = 8192;
   localparam int BANK_SHIFT = 13;
   localparam int BANK_WORDS = 2048;
   localparam int DA_SIZE = 65536;
   localparam int SA_SIZE = 98304;
   localparam int ROM_SIZE = 32768;
   localparam int ROM_WORDS = 8192;
   localparam int DA_BANKS = 8;
   localparam int SA_BANKS = 12;

   // ***********************************
   // Targets and per-cycle capacity
   // ***********************************
   localparam logic [4:0] T_SA0 = 5'h08;
   localparam logic [4:0] T_ROM = 5'h14;
   localparam logic [4:0] T_EXT = 5'h15;
   localparam logic [4:0] T_IO = 5'h16;
   localparam logic [4:0] T_ERR = 5'h17;
   localparam int NTGT = 24;
   localparam logic [1:0] DA_CAP = 2'h2;
   localparam logic [1:0] ONE_CAP = 2'h1;

   // ***********************************
   // Boot
   // ***********************************
   localparam logic [2:0] BOOT_ROM_OFF = 3'h0;
   localparam logic [2:0] BOOT_MODE_RST = 3'h0;

   // ***********************************
   // Carriers
   // ***********************************
   typedef struct packed {
      logic req;
      logic we;
      logic io;
      logic wide;
      logic [23:0] addr;
      logic [15:0] wdata;
   } tcm_req_type;

   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] data;
   } tcm_rsp_type;

   typedef struct packed {
      logic req;
      logic we;
      logic wide;
      logic cacheable;
      logic [23:0] addr;
      logic [15:0] wdata;
   } tcm_ext_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tcm_io_type;

   typedef struct packed {
      logic rom_en;
      logic [2:0] boot_mode;
      tcm_rsp_type [NREQ-1:0] rsp;
   } tcm_state_type;

endpackage

// [logic/tcm_memory.sv]
// Tightly coupled memory system: banked dual and single access RAM, boot ROM,
// external and peripheral forwarding with per-bank arbitration.
// Assumes requesters hold req and its fields stable until ready.
`timescale 1ns/1ps

module tcm_memory #(
   parameter int DA_NUM = tcm_pkg::DA_BANKS,
   parameter int SA_NUM = tcm_pkg::SA_BANKS,
   parameter logic [31:0] BOOT_WORD0 = 32'h0000_0000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Boot mode strap from host processor
   input wire logic [2:0] boot_mode_in,
   // Core buses: program, three data read, two data write, DMA
   input tcm_pkg::tcm_req_type req_in [tcm_pkg::NREQ],
   output logic [tcm_pkg::NREQ-1:0] ready_out,
   output tcm_pkg::tcm_rsp_type rsp_out [tcm_pkg::NREQ],
   // External memory path
   output tcm_pkg::tcm_ext_type ext_out,
   input wire logic ext_ready,
   input wire logic [31:0] ext_rdata,
   // Peripheral space
   output tcm_pkg::tcm_io_type io_out,
   input wire logic io_ready,
   input wire logic [15:0] io_rdata,
   // Boot status
   output logic rom_enabled,
   output logic [2:0] boot_mode_out,
   output logic [23:0] reset_vector
);
   import tcm_pkg::*;

   // ***********************************
   // Elaboration checks
   // ***********************************
   if (DA_NUM * BANK_BYTES != DA_SIZE) begin : g_da_chk
      $error("dual access bank count does not fill its region");
   end
   if (SA_NUM * BANK_BYTES != SA_SIZE) begin : g_sa_chk
      $error("single access bank count does not fill its region");
   end

   // ***********************************
   // Storage
   // ***********************************
   logic [31:0] mem [DA_BANKS+SA_BANKS][BANK_WORDS];
   tcm_state_type s_r;
   tcm_state_type s_nxt;
   logic [4:0] tgt_c [NREQ];
   logic [23:0] badr_c [NREQ];
   logic [NREQ-1:0] we_c;

   // ***********************************
   // Functions
   // ***********************************
   function automatic logic [23:0] to_byte(input logic word_bus, input logic [23:0] a);
      to_byte = word_bus ? {a[22:0], 1'b0} : a;
   endfunction

   function automatic logic [4:0] decode(input logic [23:0] b, input logic io,
                                          input logic wr, input logic dma,
                                          input logic rom_en);
      logic [23:0] off;
      off = b - SA_BASE;
      if (io) begin
         decode = T_IO;
      end else if (b < SA_BASE) begin
         decode = {2'b00, b[15:13]};
      end else if (b < EXT_BASE) begin
         decode = T_SA0 + 5'(off >> BANK_SHIFT);
      end else if (rom_en && b >= ROM_BASE) begin
         decode = (wr || dma) ? T_ERR : T_ROM;
      end else begin
         decode = T_EXT;
      end
   endfunction

   function automatic logic [1:0] capacity(input logic [4:0] t);
      capacity = (t < T_SA0) ? DA_CAP : ONE_CAP;
   endfunction

   function automatic logic [31:0] rom_word(input logic [12:0] idx);
      rom_word = (idx == 13'h0000) ? BOOT_WORD0 : 32'h0000_0000;
   endfunction

   function automatic logic [31:0] pick(input logic [31:0] w, input logic wide,
                                        input logic hi);
      if (wide) begin
         pick = w;
      end else begin
         pick = {16'h0000, hi ? w[31:16] : w[15:0]};
      end
   endfunction

   // ***********************************
   // Arbitration and response
   // ***********************************
   always_comb begin
      logic [1:0] cnt [NTGT];
      logic [23:0] b;
      logic [4:0] t;
      logic [31:0] w;
      logic io;
      logic wd;
      for (int k = 0; k < NTGT; k++) begin
         cnt[k] = 2'h0;
      end
      b = 24'h000000;
      t = T_ERR;
      w = 32'h0000_0000;
      io = 1'b0;
      wd = 1'b0;
      s_nxt = s_r;
      ready_out = '0;
      ext_out = '0;
      io_out = '0;
      we_c = '0;
      for (int i = 0; i < NREQ; i++) begin
         s_nxt.rsp[i].valid = 1'b0;
         s_nxt.rsp[i].err = 1'b0;
         io = req_in[i].io & REQ_CAN_IO[i];
         wd = req_in[i].wide | (i == REQ_PROG);
         b = to_byte(REQ_WORD_ADDR[i], req_in[i].addr);
         we_c[i] = req_in[i].we & REQ_CAN_WRITE[i];
         t = decode(b, io, we_c[i], (i == REQ_DMA), s_r.rom_en);
         tgt_c[i] = t;
         badr_c[i] = b;
         if (req_in[i].req) begin
            if (t == T_ERR) begin
               ready_out[i] = 1'b1;
            end else if (cnt[t] < capacity(t)) begin
               cnt[t] = cnt[t] + 2'h1;
               if (t == T_EXT) begin
                  ext_out.req = 1'b1;
                  ext_out.we = we_c[i];
                  ext_out.wide = wd;
                  ext_out.cacheable = (i == REQ_PROG);
                  ext_out.addr = b;
                  ext_out.wdata = req_in[i].wdata;
                  ready_out[i] = ext_ready;
               end else if (t == T_IO) begin
                  io_out.req = 1'b1;
                  io_out.we = we_c[i];
                  io_out.addr = req_in[i].addr[15:0];
                  io_out.wdata = req_in[i].wdata;
                  ready_out[i] = io_ready;
               end else begin
                  ready_out[i] = 1'b1;
               end
            end
         end
         unique case (1'b1)
            (t == T_EXT): w = ext_rdata;
            (t == T_IO): w = {16'h0000, io_rdata};
            (t == T_ROM): w = rom_word(b[14:2]);
            (t == T_ERR): w = 32'h0000_0000;
            default: w = mem[t][b[12:2]];
         endcase
         if (ready_out[i]) begin
            s_nxt.rsp[i].valid = 1'b1;
            s_nxt.rsp[i].err = (t == T_ERR);
            if (!we_c[i]) begin
               s_nxt.rsp[i].data = (t == T_IO) ? w : pick(w, wd, b[1]);
            end
         end
      end
      if (reset) begin
         s_nxt.boot_mode = boot_mode_in;
         s_nxt.rom_en = (boot_mode_in != BOOT_ROM_OFF);
         for (int i = 0; i < NREQ; i++) begin
            s_nxt.rsp[i] = '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      s_r <= s_nxt;
   end

   // ***********************************
   // RAM writes
   // ***********************************
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NREQ; i++) begin
         if (!reset && ready_out[i] && we_c[i] && tgt_c[i] < T_ROM) begin
            if (badr_c[i][1]) begin
               mem[tgt_c[i]][badr_c[i][12:2]][31:16] <= req_in[i].wdata;
            end else begin
               mem[tgt_c[i]][badr_c[i][12:2]][15:0] <= req_in[i].wdata;
            end
         end
      end
   end

   // ***********************************
   // Outputs
   // ***********************************
   always_comb begin
      for (int i = 0; i < NREQ; i++) begin
         rsp_out[i] = s_r.rsp[i];
      end
   end

   assign rom_enabled = s_r.rom_en;
   assign boot_mode_out = s_r.boot_mode;
   assign reset_vector = ROM_BASE;

endmodule

// [verification/tcm_memory_sva.sv]
// Port checker for the tightly coupled memory.
// Assumes it is bound to tcm_memory and sees only its ports.
`timescale 1ns/1ps
module tcm_memory_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Core buses
   input tcm_pkg::tcm_req_type req_in [tcm_pkg::NREQ],
   input wire logic [tcm_pkg::NREQ-1:0] ready_out,
   input tcm_pkg::tcm_rsp_type rsp_out [tcm_pkg::NREQ],
   // Far side
   input tcm_pkg::tcm_ext_type ext_out,
   input tcm_pkg::tcm_io_type io_out,
   // Boot status
   input wire logic rom_enabled,
   input wire logic [2:0] boot_mode_out,
   input wire logic [23:0] reset_vector
);
   import tcm_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_DR_ANSWER: assert property (req_in[1].req && ready_out[1] |=> rsp_out[1].valid)
      else $error("read answer missing");
   AST_DMA_CAUSE: assert property (rsp_out[6].valid |-> $past(req_in[6].req && ready_out[6]))
      else $error("answer without grant");
   AST_ROM_DMA_ERR: assert property (req_in[6].req && ready_out[6] && rom_enabled
      && req_in[6].addr >= ROM_BASE |=> rsp_out[6].err) else $error("rom dma not refused");
   AST_ROM_FLAG: assert property (rom_enabled == (boot_mode_out != BOOT_ROM_OFF))
      else $error("rom enable wrong");
   AST_VECTOR: assert property (reset_vector == ROM_BASE)
      else $error("reset vector wrong");
   AST_BOOT_HOLD: assert property (!$past(reset) |-> $stable(boot_mode_out))
      else $error("boot mode moved");
   AST_CACHE: assert property (req_in[0].req && ready_out[0] && req_in[0].addr >= EXT_BASE
      && !(rom_enabled && req_in[0].addr >= ROM_BASE) |-> ext_out.req && ext_out.cacheable)
      else $error("fetch not cacheable");
   AST_IO_FWD: assert property (req_in[1].req && req_in[1].io && ready_out[1]
      |-> io_out.req && io_out.addr == req_in[1].addr[15:0]) else $error("io not forwarded");
endmodule

// [verification/tcm_far_side.sv]
// Model of external memory and peripheral space.
// Assumes the core clock; external answers slowly, peripherals promptly.
`timescale 1ns/1ps
module tcm_far_side (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // External memory
   input tcm_pkg::tcm_ext_type ext_in,
   output logic ext_ready,
   output logic [31:0] ext_rdata,
   // Peripherals
   input tcm_pkg::tcm_io_type io_in,
   output logic io_ready,
   output logic [15:0] io_rdata
);
   logic [1:0] wait_r;
   always_ff @(posedge mclk)
      wait_r <= (reset || !ext_in.req || ext_ready) ? 2'h0 : wait_r + 2'h1;
   assign ext_ready = ext_in.req && wait_r == 2'h2;
   assign ext_rdata = ext_ready ? {8'ha5, ext_in.addr} : ~{8'ha5, ext_in.addr};
   assign io_ready = io_in.req;
   assign io_rdata = io_ready ? ~io_in.addr : io_in.addr;
endmodule

// [verification/tb_tcm_memory.sv]
// Testbench for the tightly coupled memory.
// Assumes tcm_memory, its checker and the far side model.
`timescale 1ns/1ps
module tb_tcm_memory;
   import tcm_pkg::*;
   logic mclk, reset, ext_ready, io_ready, rom_enabled;
   logic [2:0] boot_mode_in, boot_mode_out;
   tcm_req_type rq [NREQ];
   logic [NREQ-1:0] ready_out;
   tcm_rsp_type rsp_out [NREQ];
   tcm_rsp_type r;
   tcm_ext_type ext_out;
   tcm_io_type io_out;
   logic [31:0] ext_rdata;
   logic [15:0] io_rdata;
   logic [23:0] reset_vector;
   int num_errors = 0;
   int n_tests = 0;

   tcm_memory tcm_memory_inst (.mclk(mclk), .reset(reset), .boot_mode_in(boot_mode_in),
      .req_in(rq), .ready_out(ready_out), .rsp_out(rsp_out), .ext_out(ext_out),
      .ext_ready(ext_ready), .ext_rdata(ext_rdata), .io_out(io_out), .io_ready(io_ready),
      .io_rdata(io_rdata), .rom_enabled(rom_enabled), .boot_mode_out(boot_mode_out),
      .reset_vector(reset_vector));
   tcm_far_side tcm_far_side_inst (.mclk(mclk), .reset(reset), .ext_in(ext_out),
      .ext_ready(ext_ready), .ext_rdata(ext_rdata), .io_in(io_out), .io_ready(io_ready),
      .io_rdata(io_rdata));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report();
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] m);
      @(posedge mclk);
      boot_mode_in <= m;
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
   endtask

   task automatic acc(input int i, input logic we, io, input logic [23:0] a,
      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      rq[i] <= '{1'b1, we, io, 1'b0, a, d};
      @(negedge mclk);
      while (ready_out[i] !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      chk("taken", 32'h1, 32'(n < 50));
      @(posedge mclk);
      rq[i].req <= 1'b0;
      @(negedge mclk);
      r = rsp_out[i];
      chk("valid", 32'h1, {31'h0, r.valid});
   endtask

   task automatic pair(input logic [23:0] a, input logic e);
      @(posedge mclk);
      rq[1] <= '{1'b1, 1'b0, 1'b0, 1'b0, a, 16'h0};
      rq[2] <= '{1'b1, 1'b0, 1'b0, 1'b0, a + 24'h1, 16'h0};
      @(negedge mclk);
      chk("first", 32'h1, {31'h0, ready_out[1]});
      chk("second", {31'h0, e}, {31'h0, ready_out[2]});
      @(posedge mclk);
      rq[1].req <= 1'b0;
      if (!e) begin
         @(negedge mclk);
         chk("later", 32'h1, {31'h0, ready_out[2]});
         @(posedge mclk);
      end
      rq[2].req <= 1'b0;
   endtask

   initial begin
      #20000;
      num_errors++;
      final_report();
   end

   initial begin
      reset = 1'b1;
      boot_mode_in = 3'h5;
      foreach (rq[i]) rq[i] = '0;
      do_reset(3'h5);
      chk("rom_on", 32'h1, {31'h0, rom_enabled});
      chk("mode", 32'h5, {29'h0, boot_mode_out});
      chk("vector", {8'h0, ROM_BASE}, {8'h0, reset_vector});
      acc(4, 1'b1, 1'b0, 24'h000010, 16'h1234);
      acc(1, 1'b0, 1'b0, 24'h000010, 16'h0);
      chk("da_data", 32'h1234, {16'h0, r.data[15:0]});
      acc(5, 1'b1, 1'b0, 24'h008003, 16'hbeef);
      acc(2, 1'b0, 1'b0, 24'h008003, 16'h0);
      chk("sa_data", 32'hbeef, {16'h0, r.data[15:0]});
      acc(6, 1'b1, 1'b0, 24'hff8000, 16'h1);
      chk("rom_err", 32'h1, {31'h0, r.err});
      acc(0, 1'b0, 1'b0, 24'h028000, 16'h0);
      chk("ext_data", 32'ha5028000, r.data);
      acc(1, 1'b0, 1'b1, 24'h000040, 16'h0);
      chk("io_data", 32'hffbf, {16'h0, r.data[15:0]});
      pair(24'h000100, 1'b1);
      pair(24'h008100, 1'b0);
      acc(0, 1'b0, 1'b0, 24'hff8000, 16'h0);
      chk("rom_word", 32'h0, r.data);
      acc(1, 1'b0, 1'b0, 24'h7fc000, 16'h0);
      chk("rom_read_err", 32'h0, {31'h0, r.err});
      do_reset(3'h0);
      chk("rom_off", 32'h0, {31'h0, rom_enabled});
      acc(0, 1'b0, 1'b0, 24'hff8000, 16'h0);
      chk("rom_ext", 32'ha5ff8000, r.data);
      final_report();
   end
endmodule

bind tcm_memory tcm_memory_sva tcm_memory_sva_inst (.mclk(mclk), .reset(reset),
   .req_in(req_in), .ready_out(ready_out), .rsp_out(rsp_out), .ext_out(ext_out),
   .io_out(io_out), .rom_enabled(rom_enabled), .boot_mode_out(boot_mode_out),
   .reset_vector(reset_vector));
